// File: hw/pt_timer_defines.vh
// Constants for the periodic timer: register offsets, field positions,
// mode and pin-action encodings, clock selects and reset values.
// Assumes an Avalon-MM byte address with one 32-bit word per register.
`ifndef PT_TIMER_DEFINES_VH
`define PT_TIMER_DEFINES_VH

// Register byte offsets
`define PT_OFS_CTRL0 6'h00
`define PT_OFS_CTRL1 6'h04
`define PT_OFS_CNTL 6'h08
`define PT_OFS_CNTH 6'h0c
`define PT_OFS_CMPAL 6'h10
`define PT_OFS_CMPAH 6'h14
`define PT_OFS_PERL 6'h18
`define PT_OFS_PERH 6'h1c
`define PT_OFS_FLAGS 6'h20

// Control 0 fields
`define PT_C0_PAUSE 7
`define PT_C0_CK_HI 6
`define PT_C0_CK_LO 4
`define PT_C0_ON 3
`define PT_C0_WMASK 8'hf8

// Control 1 fields
`define PT_C1_MODE_HI 7
`define PT_C1_MODE_LO 6
`define PT_C1_IO_HI 5
`define PT_C1_IO_LO 4
`define PT_C1_OC 3
`define PT_C1_POL 2
`define PT_C1_CAPTS 1
`define PT_C1_CCLR 0

// Flag register fields, write one to clear
`define PT_FL_A 0
`define PT_FL_P 1

// Operating modes
`define PT_MODE_CMP 2'b00
`define PT_MODE_CAP 2'b01
`define PT_MODE_PWM 2'b10
`define PT_MODE_TC 2'b11

// Pin-action codes
`define PT_IO_00 2'b00
`define PT_IO_01 2'b01
`define PT_IO_10 2'b10
`define PT_IO_11 2'b11

// Counter clock selects
`define PT_CK_DIV4 3'b000
`define PT_CK_SYS 3'b001
`define PT_CK_DIV16 3'b010
`define PT_CK_DIV64 3'b011
`define PT_CK_SUBA 3'b100
`define PT_CK_SUBB 3'b101
`define PT_CK_EXTR 3'b110
`define PT_CK_EXTF 3'b111

// Prescaler masks, a tick when all masked bits are ones
`define PT_DIV_W 6
`define PT_MASK4 6'h03
`define PT_MASK16 6'h0f
`define PT_MASK64 6'h3f

// Counter and register values
`define PT_CNT_ZERO 10'h000
`define PT_CNT_ONE 10'h001
`define PT_CNT_MAX 10'h3ff
`define PT_BYTE_ZERO 8'h00
`define PT_HIGH_PAD 6'h00
`define PT_RDATA_PAD 24'h000000

`endif

// File: hw/pt_timer.v
// Periodic 10-bit timer: counter, comparators A and P, five modes,
// byte-wide registers behind an Avalon-MM slave with waitrequest.
// Assumes pins are synchronous to clock; subClockTick is a one-cycle
// strobe from the slow sub clock domain, already synchronised.
//
// The register offsets and the Avalon-MM interface to the registers are this design's own decisions.
`include "pt_timer_defines.vh"

module pt_timer #(
    parameter ADDR_W = 6,
    parameter DATA_W = 32,
    parameter CNT_W = 10
)(
    input wire clock,
    input wire reset,
    input wire clockEnable,
    input wire [ADDR_W-1:0] address,
    input wire read,
    input wire write,
    input wire [DATA_W-1:0] writedata,
    input wire [3:0] byteenable,
    output reg [DATA_W-1:0] readdata,
    output reg waitrequest,
    input wire extClockPin,
    input wire captureInputPin,
    input wire subClockTick,
    output reg timerOutputPin,
    output reg timerOutputEn
);

    // Zero-extend a byte onto the bus word
    function [DATA_W-1:0] busWord;
        input [7:0] b;
        begin
            busWord = {`PT_RDATA_PAD, b};
        end
    endfunction

    // High register view: bits 9..8 low, unimplemented bits zero
    function [7:0] highBits;
        input [CNT_W-1:0] v;
        begin
            highBits = {`PT_HIGH_PAD, v[CNT_W-1:8]};
        end
    endfunction

    reg [7:0] ctrl0_r;
    reg [7:0] ctrl1_r;
    reg [CNT_W-1:0] cnt_r;
    reg [CNT_W-1:0] cmpA_r;
    reg [CNT_W-1:0] per_r;
    reg flagA_r;
    reg flagP_r;
    reg enPrev_r;
    reg pinLvl_r;
    reg extPrev_r;
    reg capPrev_r;
    reg [`PT_DIV_W-1:0] div_r;
    reg [DATA_W-1:0] rdata_nxt;
    reg tick;
    reg pwmAct;
    reg lvl;
    reg capEdge;

    wire en = ctrl0_r[`PT_C0_ON];
    wire pause = ctrl0_r[`PT_C0_PAUSE];
    wire [2:0] ckSel = ctrl0_r[`PT_C0_CK_HI:`PT_C0_CK_LO];
    wire [1:0] mode = ctrl1_r[`PT_C1_MODE_HI:`PT_C1_MODE_LO];
    wire [1:0] pinAct = ctrl1_r[`PT_C1_IO_HI:`PT_C1_IO_LO];
    wire outLvlCtrl = ctrl1_r[`PT_C1_OC];
    wire invert = ctrl1_r[`PT_C1_POL];
    wire capSrc = ctrl1_r[`PT_C1_CAPTS];
    wire clrSel = ctrl1_r[`PT_C1_CCLR];

    // Bus handshake: accept only on the cycle waitrequest is low
    wire reqTaken = (read | write) & ~waitrequest;
    wire wrLow = write & ~waitrequest & byteenable[0];
    wire [7:0] wb = writedata[7:0];

    // Mode decode
    wire singlePulse = (mode == `PT_MODE_PWM) && (pinAct == `PT_IO_11);
    wire cmpLike = (mode == `PT_MODE_CMP) || (mode == `PT_MODE_TC);

    // Edges on the external pins, compared against last cycle's level
    // Last levels reset low, the pins' idle level, so no false edge follows reset
    wire extRise = extClockPin & ~extPrev_r;
    wire extFall = ~extClockPin & extPrev_r;
    wire capRise = captureInputPin & ~capPrev_r;
    wire capFall = ~captureInputPin & capPrev_r;
    wire enRise = en & ~enPrev_r;

    // Comparator results
    // A period of zero stands for the full 1024-count cycle
    wire perZero = (per_r == `PT_CNT_ZERO);
    wire atMax = (cnt_r == `PT_CNT_MAX);
    wire aHit = (cmpA_r != `PT_CNT_ZERO) && (cnt_r == cmpA_r);
    wire pHit = perZero ? atMax : (cnt_r == per_r);
    wire [CNT_W-1:0] pwmEnd = perZero ? `PT_CNT_MAX : per_r - `PT_CNT_ONE;
    wire pwmAHit = (cnt_r == cmpA_r);
    wire run = en & ~pause & tick;
    wire [CNT_W-1:0] cntInc = cnt_r + `PT_CNT_ONE;

    // Counter clock select; sub clock arrives as a strobe already
    always @*
    begin
        case (ckSel)
            `PT_CK_DIV4: tick = ((div_r & `PT_MASK4) == `PT_MASK4);
            `PT_CK_SYS: tick = 1'b1;
            `PT_CK_DIV16: tick = ((div_r & `PT_MASK16) == `PT_MASK16);
            `PT_CK_DIV64: tick = ((div_r & `PT_MASK64) == `PT_MASK64);
            `PT_CK_SUBA: tick = subClockTick;
            `PT_CK_SUBB: tick = subClockTick;
            `PT_CK_EXTR: tick = extRise;
            `PT_CK_EXTF: tick = extFall;
            default: tick = 1'b0;
        endcase
    end

    // Capture trigger selection; the pin is sensed even if shared as output
    always @*
    begin
        case (pinAct)
            `PT_IO_00: capEdge = capSrc ? extRise : capRise;
            `PT_IO_01: capEdge = capSrc ? extFall : capFall;
            `PT_IO_10: capEdge = capSrc ? (extRise | extFall) : (capRise | capFall);
            default: capEdge = 1'b0;
        endcase
    end

    // PWM active phase; a duty at or past the period holds the pin active
    always @*
    begin
        pwmAct = (cnt_r < cmpA_r) || ({1'b0, cmpA_r} >= {perZero, per_r});
        case (pinAct)
            `PT_IO_00: lvl = ~outLvlCtrl;
            `PT_IO_01: lvl = outLvlCtrl;
            `PT_IO_10: lvl = outLvlCtrl ? (en & pwmAct) : ~(en & pwmAct);
            `PT_IO_11: lvl = outLvlCtrl ? en : ~en;
            default: lvl = 1'b0;
        endcase
        if (mode == `PT_MODE_CMP)
        begin
            lvl = pinLvl_r;
        end
    end

    // Read mux; unmapped offsets return zero
    always @*
    begin
        case (address)
            `PT_OFS_CTRL0: rdata_nxt = busWord(ctrl0_r);
            `PT_OFS_CTRL1: rdata_nxt = busWord(ctrl1_r);
            `PT_OFS_CNTL: rdata_nxt = busWord(cnt_r[7:0]);
            `PT_OFS_CNTH: rdata_nxt = busWord(highBits(cnt_r));
            `PT_OFS_CMPAL: rdata_nxt = busWord(cmpA_r[7:0]);
            `PT_OFS_CMPAH: rdata_nxt = busWord(highBits(cmpA_r));
            `PT_OFS_PERL: rdata_nxt = busWord(per_r[7:0]);
            `PT_OFS_PERH: rdata_nxt = busWord(highBits(per_r));
            `PT_OFS_FLAGS: rdata_nxt = busWord({`PT_HIGH_PAD, flagP_r, flagA_r});
            default: rdata_nxt = busWord(`PT_BYTE_ZERO);
        endcase
    end

    // Bus slave: one wait cycle, then a one-cycle acknowledge
    // A request held while clock enable is low is answered once it returns high
    always @(posedge clock)
    begin
        if (reset)
        begin
            waitrequest <= 1'b1;
            readdata <= {DATA_W{1'b0}};
        end
        else if (clockEnable)
        begin
            if ((read | write) & waitrequest)
            begin
                waitrequest <= 1'b0;
                readdata <= rdata_nxt;
            end
            else
            begin
                waitrequest <= 1'b1;
            end
        end
    end

    // Timer core: software writes first, hardware events override them
    // Placing hardware sets after the write block makes a same-cycle set beat a clear
    always @(posedge clock)
    begin
        if (reset)
        begin
            ctrl0_r <= `PT_BYTE_ZERO;
            ctrl1_r <= `PT_BYTE_ZERO;
            cnt_r <= `PT_CNT_ZERO;
            cmpA_r <= `PT_CNT_ZERO;
            per_r <= `PT_CNT_ZERO;
            flagA_r <= 1'b0;
            flagP_r <= 1'b0;
            enPrev_r <= 1'b0;
            pinLvl_r <= 1'b0;
            extPrev_r <= 1'b0;
            capPrev_r <= 1'b0;
            div_r <= {`PT_DIV_W{1'b0}};
        end
        else if (clockEnable)
        begin
            // Prescaler runs free; its phase is not tied to the enable
            div_r <= div_r + 1'b1;
            extPrev_r <= extClockPin;
            capPrev_r <= captureInputPin;
            enPrev_r <= en;
            if (wrLow)
            begin
                case (address)
                    `PT_OFS_CTRL0: ctrl0_r <= wb & `PT_C0_WMASK;
                    `PT_OFS_CTRL1: ctrl1_r <= wb;
                    `PT_OFS_CMPAL: cmpA_r[7:0] <= wb;
                    `PT_OFS_CMPAH: cmpA_r[CNT_W-1:8] <= wb[1:0];
                    `PT_OFS_PERL: per_r[7:0] <= wb;
                    `PT_OFS_PERH: per_r[CNT_W-1:8] <= wb[1:0];
                    `PT_OFS_FLAGS:
                    begin
                        // Write one to clear; a same-cycle set below wins
                        if (wb[`PT_FL_A])
                        begin
                            flagA_r <= 1'b0;
                        end
                        if (wb[`PT_FL_P])
                        begin
                            flagP_r <= 1'b0;
                        end
                    end
                    default: ;
                endcase
            end

            // External pin edge arms a single pulse
            // Only a rising edge arms, so a pin held high cannot re-arm after a match
            if (singlePulse && !en && extRise)
            begin
                ctrl0_r[`PT_C0_ON] <= 1'b1;
            end

            // Enable rise restarts from zero and reloads the initial pin level
            if (enRise)
            begin
                cnt_r <= `PT_CNT_ZERO;
                pinLvl_r <= outLvlCtrl;
            end
            else if (run)
            begin
                if (cmpLike)
                begin
                    if (aHit)
                    begin
                        flagA_r <= 1'b1;
                        // Pin follows A matches only, never P
                        case (pinAct)
                            `PT_IO_01: pinLvl_r <= 1'b0;
                            `PT_IO_10: pinLvl_r <= 1'b1;
                            `PT_IO_11: pinLvl_r <= ~pinLvl_r;
                            default: pinLvl_r <= pinLvl_r;
                        endcase
                    end
                    if (clrSel)
                    begin
                        cnt_r <= aHit ? `PT_CNT_ZERO : cntInc;
                    end
                    else if (pHit)
                    begin
                        cnt_r <= `PT_CNT_ZERO;
                        flagP_r <= 1'b1;
                    end
                    else
                    begin
                        cnt_r <= cntInc;
                    end
                end
                else if (mode == `PT_MODE_PWM)
                begin
                    if (singlePulse)
                    begin
                        // Period and clear-select have no say here
                        cnt_r <= cntInc;
                        if (aHit)
                        begin
                            flagA_r <= 1'b1;
                            ctrl0_r[`PT_C0_ON] <= 1'b0;
                        end
                    end
                    else
                    begin
                        cnt_r <= (cnt_r == pwmEnd) ? `PT_CNT_ZERO : cntInc;
                        if (pwmAHit)
                        begin
                            flagA_r <= 1'b1;
                        end
                        if (cnt_r == pwmEnd)
                        begin
                            flagP_r <= 1'b1;
                        end
                    end
                end
                else
                begin
                    // Capture mode runs free, bounded by the period
                    if (pHit)
                    begin
                        cnt_r <= `PT_CNT_ZERO;
                        flagP_r <= 1'b1;
                    end
                    else
                    begin
                        cnt_r <= cntInc;
                    end
                end
            end

            // Capture overrides a software write to compare A in the same cycle
            // A stopped timer takes no captures, whatever the pins do
            if ((mode == `PT_MODE_CAP) && en && capEdge)
            begin
                cmpA_r <= cnt_r;
                flagA_r <= 1'b1;
            end
        end
    end

    // Pin stage; timer mode and capture mode leave the pin to others
    // Invert acts last, so forced, PWM and pulse levels all follow it
    always @(posedge clock)
    begin
        if (reset)
        begin
            timerOutputPin <= 1'b0;
            timerOutputEn <= 1'b0;
        end
        else if (clockEnable)
        begin
            timerOutputPin <= invert ? ~lvl : lvl;
            timerOutputEn <= (mode == `PT_MODE_CMP) || (mode == `PT_MODE_PWM);
        end
    end

endmodule // pt_timer

// File: testbench/pt_timer_sva.sv
// Checker for the periodic timer: bus handshake and pin behaviour at the ports.
// Assumes it is bound to pt_timer and sees only its ports.
`include "pt_timer_defines.vh"
module pt_timer_sva #(
    parameter ADDR_W = 6,
    parameter DATA_W = 32
)(
    input wire clock,
    input wire reset,
    input wire clockEnable,
    input wire [ADDR_W-1:0] address,
    input wire read,
    input wire write,
    input wire [DATA_W-1:0] writedata,
    input wire [3:0] byteenable,
    input wire [DATA_W-1:0] readdata,
    input wire waitrequest,
    input wire timerOutputPin,
    input wire timerOutputEn
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] mode_r, io_r;
    logic oc_r, pol_r, on_r;
    logic [2:0] cfgAge_r;
    wire take = write && !waitrequest && clockEnable && byteenable[0];
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    // Shadow of software control writes; auto enable changes are not tracked
    always @(posedge clock)
    begin
        if (reset)
        begin
            {mode_r, io_r, oc_r, pol_r, on_r} <= 7'h00;
            cfgAge_r <= 3'h0;
        end
        else if (take && address == `PT_OFS_CTRL1)
        begin
            {mode_r, io_r, oc_r, pol_r} <= writedata[7:2];
            cfgAge_r <= 3'h0;
        end
        else if (take && address == `PT_OFS_CTRL0)
        begin
            on_r <= writedata[3];
            cfgAge_r <= 3'h0;
        end
        else if (cfgAge_r != 3'h7)
            cfgAge_r <= cfgAge_r + 3'h1;
    end
    property p_ack_next; (read || write) && waitrequest && clockEnable |=> !waitrequest; endproperty
    a_ack_next: assert property (p_ack_next) else $error("request not answered after one wait cycle");
    property p_wait_one; !waitrequest && clockEnable |=> waitrequest; endproperty
    a_wait_one: assert property (p_wait_one) else $error("waitrequest low longer than one cycle");
    property p_no_ack; !read && !write && waitrequest |=> waitrequest; endproperty
    a_no_ack: assert property (p_no_ack) else $error("answer without a request");
    property p_rdata_hold; waitrequest |-> $stable(readdata); endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved outside an answer");
    property p_hi_zero;
        !waitrequest && read && (address == `PT_OFS_CNTH || address == `PT_OFS_CMPAH || address == `PT_OFS_PERH)
        |-> readdata[7:2] == 6'h00;
    endproperty
    a_hi_zero: assert property (p_hi_zero) else $error("high register upper bits not zero");
    property p_tc_no_drive; mode_r == `PT_MODE_TC && $stable(mode_r) |-> !timerOutputEn; endproperty
    a_tc_no_drive: assert property (p_tc_no_drive) else $error("pin driven in timer mode");
    property p_cap_no_drive; mode_r == `PT_MODE_CAP && $stable(mode_r) |-> !timerOutputEn; endproperty
    a_cap_no_drive: assert property (p_cap_no_drive) else $error("pin driven in capture mode");
    property p_pwm_forced;
        mode_r == `PT_MODE_PWM && !io_r[1] && on_r && cfgAge_r >= 3'h4
        |-> timerOutputPin == ((io_r[0] ? oc_r : !oc_r) ^ pol_r);
    endproperty
    a_pwm_forced: assert property (p_pwm_forced) else $error("forced pwm level wrong");
    property p_cmp_init; $rose(on_r) && mode_r == `PT_MODE_CMP |-> ##2 timerOutputPin == (oc_r ^ pol_r); endproperty
    a_cmp_init: assert property (p_cmp_init) else $error("pin not at initial level after enable");
    cover property (!waitrequest && read);
    cover property ($rose(on_r) && mode_r == `PT_MODE_CMP);
    cover property (mode_r == `PT_MODE_PWM && io_r == 2'b01 && on_r && cfgAge_r >= 3'h4);
endmodule // pt_timer_sva

// File: testbench/pt_pin_model.sv
// Pin-side model: drives the clock/trigger pin, capture pin and sub clock strobe.
// Assumes the bench calls one task at a time, from its main process.
module pt_pin_model (
    input wire logic clock,
    output logic extClockPin,
    output logic captureInputPin,
    output logic subClockTick
);
    timeunit 1ns;
    timeprecision 1ps;
    // Quiet levels at time zero
    initial
    begin
        extClockPin = 1'b0;
        captureInputPin = 1'b0;
        subClockTick = 1'b0;
    end
    // Levels move after an edge, then settle past the design's pin sampling
    task automatic setExt(input logic v);
        @(posedge clock);
        extClockPin <= v;
        repeat (4) @(posedge clock);
    endtask
    task automatic setCap(input logic v);
        @(posedge clock);
        captureInputPin <= v;
        repeat (4) @(posedge clock);
    endtask
    // Strobes have a gap, so each one is a distinct counter tick
    task automatic ticks(input int n);
        repeat (n)
        begin
            @(posedge clock);
            subClockTick <= 1'b1;
            @(posedge clock);
            subClockTick <= 1'b0;
        end
        repeat (4) @(posedge clock);
    endtask
endmodule // pt_pin_model

// File: testbench/pt_timer_tb.sv
// Testbench for the periodic timer: register access and five-mode pin scenarios.
// Assumes the design and its defines header are on the include path.
`include "pt_timer_defines.vh"
`define CHK(nm, e, g) begin nTests++; if ((g) !== (e)) begin nErrors++; $display("CHECK FAILED %s exp %0h seen %0h", nm, e, g); end end
module pt_timer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, reset, clockEnable, read, write;
    logic [5:0] address;
    logic [31:0] writedata, readdata;
    logic [3:0] byteenable;
    logic waitrequest, extClockPin, captureInputPin, subClockTick, timerOutputPin, timerOutputEn;
    logic [7:0] rv;
    int nErrors = 0, nTests = 0, highs, flips;
    int pP[6] = '{10, 10, 10, 0, 10, 10};
    int pA[6] = '{3, 12, 3, 512, 3, 3};
    int pIo[6] = '{2, 2, 2, 2, 0, 1};
    int pPol[6] = '{0, 0, 1, 0, 0, 0};
    int pW[6] = '{100, 100, 100, 1024, 100, 100};
    int pHi[6] = '{30, 100, 70, 512, 0, 100};
    pt_timer dut (.clock(clock), .reset(reset), .clockEnable(clockEnable), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .extClockPin(extClockPin), .captureInputPin(captureInputPin),
        .subClockTick(subClockTick), .timerOutputPin(timerOutputPin), .timerOutputEn(timerOutputEn));
    pt_pin_model pins (.clock(clock), .extClockPin(extClockPin), .captureInputPin(captureInputPin),
        .subClockTick(subClockTick));
    // One bus transfer, held until waitrequest is sampled low
    task automatic xfer(input logic wr, input logic [5:0] a, input logic [7:0] d, input logic [3:0] be);
        int n = 0;
        @(posedge clock);
        read <= !wr;
        write <= wr;
        address <= a;
        writedata <= {24'h0, d};
        byteenable <= be;
        @(posedge clock);
        while (waitrequest !== 1'b0 && n < 50)
        begin
            n++;
            @(posedge clock);
        end
        if (n == 50) nErrors++;
        rv = readdata[7:0];
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        xfer(1'b1, a, d, 4'h1);
    endtask
    task automatic rdc(input string nm, input logic [5:0] a, input logic [7:0] e);
        xfer(1'b0, a, 8'h00, 4'h1);
        `CHK(nm, e, rv)
    endtask
    // Stop, clear flags, load the setup, then start; stopping first avoids mid-run mode changes
    task automatic cfg(input logic [7:0] c1, input logic [9:0] a, input logic [9:0] p, input logic [7:0] c0);
        wr(`PT_OFS_CTRL0, 8'h00);
        wr(`PT_OFS_FLAGS, 8'h03);
        wr(`PT_OFS_CTRL1, c1);
        wr(`PT_OFS_CMPAL, a[7:0]);
        wr(`PT_OFS_CMPAH, {6'h00, a[9:8]});
        wr(`PT_OFS_PERL, p[7:0]);
        wr(`PT_OFS_PERH, {6'h00, p[9:8]});
        wr(`PT_OFS_CTRL0, c0);
    endtask
    // Count high samples and level changes of the pin over w cycles
    task automatic watch(input int w);
        logic last;
        highs = 0;
        flips = 0;
        @(posedge clock);
        last = timerOutputPin;
        repeat (w)
        begin
            @(posedge clock);
            highs += (timerOutputPin === 1'b1);
            flips += (timerOutputPin !== last);
            last = timerOutputPin;
        end
    endtask
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", nTests, nErrors);
        if (nErrors == 0 && nTests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    // Hang guard, well past the expected run length
    initial
    begin
        repeat (60000) @(posedge clock);
        nErrors++;
        summarize();
    end
    initial
    begin
        reset = 1'b1;
        clockEnable = 1'b1;
        read = 1'b0;
        write = 1'b0;
        address = 6'h00;
        writedata = 32'h0;
        byteenable = 4'h1;
        repeat (12) @(posedge clock);
        reset <= 1'b0;
        for (int o = 8; o <= 28; o += 4) rdc("reset value", o[5:0], 8'h00);
        rdc("unmapped", 6'h3c, 8'h00);
        wr(`PT_OFS_CMPAH, 8'hff);
        rdc("cmpah", `PT_OFS_CMPAH, 8'h03);
        wr(`PT_OFS_PERH, 8'hfe);
        rdc("perh", `PT_OFS_PERH, 8'h02);
        wr(`PT_OFS_PERL, 8'h5a);
        rdc("perl", `PT_OFS_PERL, 8'h5a);
        xfer(1'b1, `PT_OFS_CMPAL, 8'h77, 4'h0);
        rdc("cmpal", `PT_OFS_CMPAL, 8'h00);
        wr(`PT_OFS_CNTL, 8'h55);
        rdc("cntl", `PT_OFS_CNTL, 8'h00);
        // Compare mode, clear on A at 4 gives a five-cycle period
        for (int io = 0; io < 4; io++)
        begin
            cfg({2'b00, io[1:0], 4'b1001}, 10'd4, 10'd2, 8'h18);
            watch(20);
            watch(50);
            `CHK("cmp flips", (io == 3) ? 10 : 0, flips)
            `CHK("cmp highs", (io == 1) ? 0 : (io == 3) ? 25 : 50, highs)
            rdc("cmp flags", `PT_OFS_FLAGS, 8'h01);
        end
        cfg(8'h00, 10'd0, 10'd0, 8'h18);
        repeat (1100) @(posedge clock);
        rdc("overflow flags", `PT_OFS_FLAGS, 8'h02);
        for (int m = 0; m < 4; m += 3)
        begin
            cfg({m[1:0], 6'h00}, 10'd3, 10'd6, 8'h18);
            repeat (20) @(posedge clock);
            rdc("flags", `PT_OFS_FLAGS, 8'h03);
            xfer(1'b0, `PT_OFS_CNTL, 8'h00, 4'h1);
            `CHK("count bound", 1'b1, rv <= 8'd6)
            `CHK("pin enable", m == 0, timerOutputEn)
        end
        for (int k = 0; k < 6; k++)
        begin
            cfg({2'b10, pIo[k][1:0], 1'b1, pPol[k][0], 2'b01}, pA[k][9:0], pP[k][9:0], 8'h18);
            watch(30);
            watch(pW[k]);
            `CHK("pwm highs", pHi[k], highs)
        end
        rdc("pwm flags", `PT_OFS_FLAGS, 8'h03);
        // Single pulse armed by the clock pin, then started and ended by software
        cfg(8'hb8, 10'd20, 10'd5, 8'h10);
        pins.setExt(1'b1);
        `CHK("pulse lead", 1'b1, timerOutputPin)
        watch(60);
        `CHK("pulse flips", 1, flips)
        rdc("pulse enable", `PT_OFS_CTRL0, 8'h10);
        rdc("pulse flag", `PT_OFS_FLAGS, 8'h01);
        pins.setExt(1'b0);
        wr(`PT_OFS_CTRL0, 8'h18);
        repeat (3) @(posedge clock);
        `CHK("pulse start", 1'b1, timerOutputPin)
        wr(`PT_OFS_CTRL0, 8'h10);
        repeat (3) @(posedge clock);
        `CHK("pulse end", 1'b0, timerOutputPin)
        // Capture with the sub clock strobe as counter clock, so counts are exact
        for (int io = 0; io < 4; io++)
        begin
            cfg({2'b01, io[1:0], 4'h0}, 10'd0, 10'd0, 8'h48);
            pins.ticks(37);
            pins.setCap(1'b1);
            pins.ticks(300);
            pins.setCap(1'b0);
            rdc("cap low", `PT_OFS_CMPAL, (io == 0) ? 8'h25 : (io == 3) ? 8'h00 : 8'h51);
            rdc("cap high", `PT_OFS_CMPAH, (io == 1 || io == 2) ? 8'h01 : 8'h00);
            rdc("cap flag", `PT_OFS_FLAGS, (io == 3) ? 8'h00 : 8'h01);
            rdc("cap count", `PT_OFS_CNTL, 8'h51);
        end
        cfg(8'h42, 10'd0, 10'd0, 8'h48);
        pins.ticks(50);
        pins.setCap(1'b1);
        pins.ticks(10);
        pins.setExt(1'b1);
        rdc("cap source", `PT_OFS_CMPAL, 8'h3c);
        cfg(8'h70, 10'd0, 10'd40, 8'h48);
        pins.ticks(45);
        rdc("cap wrap", `PT_OFS_CNTL, 8'h04);
        rdc("cap p flag", `PT_OFS_FLAGS, 8'h02);
        // Clock enable low freezes the counter, so strobes in that span are lost
        clockEnable <= 1'b0;
        pins.ticks(5);
        clockEnable <= 1'b1;
        rdc("frozen count", `PT_OFS_CNTL, 8'h04);
        pins.ticks(3);
        rdc("resumed count", `PT_OFS_CNTL, 8'h07);
        summarize();
    end
endmodule // pt_timer_tb
bind pt_timer pt_timer_sva #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk (.clock(clock), .reset(reset),
    .clockEnable(clockEnable), .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest), .timerOutputPin(timerOutputPin),
    .timerOutputEn(timerOutputEn));
